// ==== verilog/sram_link_pkg.sv ====
// Shared constants and types for the burst-of-four SRAM link and its controller
// Contract
// - Static clock beyond 30 ns resets loop
// - Bypass pin rising edge resets loop
// - Lock period elapses before normal operation
// - Early bypass release needs loop reset later
// - Frequency change needs loop reset, relock
// - Power-on holds every input at defined level
// - Burst addresses are base plus zero..three
// - Read select low means read request
// - Write select low means write request
// - Read and write machines run concurrently
// - Control sequencing on true clock rise
// - Reference pattern: read, then write next
// - Same-type command on next rise ignored
// - Both after idle cycle: write ignored
// - Drain pending bursts before stopping clocks
package sram_link_pkg;

  // Core clock and loop timing
  localparam int CLK_PERIOD_NS   = 20;
  localparam int STOP_NS         = 30;
  localparam int STOP_CYC        = (STOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STOP_HOLD_CYC   = STOP_CYC + 2;
  localparam int LOCK_CYCLES     = 2048;
  localparam int LOCK_MARGIN     = 2;
  localparam int BYPASS_LOW_NS   = 100;
  localparam int BYPASS_LOW_CYC  = (BYPASS_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PWR_HOLD_CYC    = 8;
  localparam int CNT_W           = 12;
  localparam int STALL_W         = 4;

  // Burst shape and latencies in half clock periods
  localparam int BURST_LEN       = 4;
  localparam int RD_LAT_HALF     = 5;
  localparam int WR_LAT_HALF     = 4;
  localparam int RD_CAPT_DLY     = RD_LAT_HALF + 2;
  localparam int ADDR_W_DEF      = 19;
  localparam int DATA_W_DEF      = 36;

  // Reset levels of the link pins
  localparam logic K_RST         = 1'b0;
  localparam logic K_N_RST       = 1'b1;
  localparam logic SEL_N_RST     = 1'b1;
  localparam logic BYPASS_N_RST  = 1'b0;

  // Controller sequencing states
  typedef enum logic [4:0] {
    ST_PWR   = 5'h01,
    ST_STOP  = 5'h02,
    ST_LOCK  = 5'h04,
    ST_RUN   = 5'h08,
    ST_DRAIN = 5'h10
  } host_state_e;

endpackage

// ==== verilog/sram_link_if.sv ====
// Pin-level link between the SRAM device and its controller
`timescale 1ns/1ps
interface sram_link_if #(
  parameter int ADDR_W = sram_link_pkg::ADDR_W_DEF,
  parameter int DATA_W = sram_link_pkg::DATA_W_DEF
);
  logic              k;
  logic              k_n;
  logic              bypass_n;
  logic              rd_sel_n;
  logic              wr_sel_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] d;
  logic [DATA_W-1:0] q;
  logic              q_oe;

  // Memory device end
  modport dev (
    input  k, k_n, bypass_n, rd_sel_n, wr_sel_n, addr, d,
    output q, q_oe
  );

  // Controller end
  modport ctl (
    output k, k_n, bypass_n, rd_sel_n, wr_sel_n, addr, d,
    input  q, q_oe
  );
endinterface

// ==== verilog/sram_burst_device.sv ====
// Burst-of-four SRAM device: loop lock, read and write burst engines, array
`timescale 1ns/1ps
module sram_burst_device #(
  parameter int ADDR_W   = sram_link_pkg::ADDR_W_DEF,
  parameter int DATA_W   = sram_link_pkg::DATA_W_DEF,
  parameter int LOCK_CYC = sram_link_pkg::LOCK_CYCLES
) (
  input  wire logic core_clk,
  input  wire logic rst,
  sram_link_if.dev  link,
  output logic      dll_ready,
  output logic      rd_busy,
  output logic      wr_busy
);
  import sram_link_pkg::*;

  localparam int MEM_W = ADDR_W + 2;

  logic [DATA_W-1:0]        mem [0:(2**MEM_W)-1];
  logic                     k_prev_reg;
  logic                     kn_prev_reg;
  logic                     byp_prev_reg;
  logic [STALL_W-1:0]       stall_reg;
  logic [CNT_W-1:0]         lock_cnt_reg;
  logic                     ready_reg;
  logic                     rd_last_reg;
  logic                     wr_last_reg;
  logic                     prev_idle_reg;
  logic [RD_LAT_HALF-1:0]   rp_v_reg;
  logic [ADDR_W-1:0]        rp_a_reg [RD_LAT_HALF];
  logic                     rs_v_reg;
  logic [ADDR_W-1:0]        rs_a_reg;
  logic [1:0]               rs_beat_reg;
  logic [WR_LAT_HALF-1:0]   wp_v_reg;
  logic [ADDR_W-1:0]        wp_a_reg [WR_LAT_HALF];
  logic                     ws_v_reg;
  logic [ADDR_W-1:0]        ws_a_reg;
  logic [1:0]               ws_beat_reg;
  logic [DATA_W-1:0]        q_reg;
  logic                     q_oe_reg;

  // Array index of one beat: burst base followed by the beat number
  function automatic logic [MEM_W-1:0] beat_idx(input logic [ADDR_W-1:0] a,
                                                input logic [1:0] b);
    return {a, b};
  endfunction

  // Clock edge and stall detection on the sampled pins
  wire k_rise     = link.k & ~k_prev_reg;
  wire kn_rise    = link.k_n & ~kn_prev_reg;
  wire tick       = k_rise | kn_rise;
  wire clk_static = (link.k == k_prev_reg) | (link.k_n == kn_prev_reg);
  wire byp_rise   = link.bypass_n & ~byp_prev_reg;
  wire loop_rst   = (stall_reg >= STALL_W'(STOP_CYC)) | byp_rise;

  // Command acceptance on the true clock rise only
  wire rd_req  = ~link.rd_sel_n;
  wire wr_req  = ~link.wr_sel_n;
  wire rd_take = k_rise & ready_reg & rd_req & ~rd_last_reg;
  wire wr_take = k_rise & ready_reg & wr_req & ~wr_last_reg
                 & ~(rd_req & prev_idle_reg);

  // Beat addressing of both engines
  wire                   rd_start = rp_v_reg[RD_LAT_HALF-1];
  wire                   wr_start = wp_v_reg[WR_LAT_HALF-1];
  wire [MEM_W-1:0]       rd_idx   = rd_start ? beat_idx(rp_a_reg[RD_LAT_HALF-1], 2'h0)
                                             : beat_idx(rs_a_reg, rs_beat_reg);
  wire [MEM_W-1:0]       wr_idx   = wr_start ? beat_idx(wp_a_reg[WR_LAT_HALF-1], 2'h0)
                                             : beat_idx(ws_a_reg, ws_beat_reg);
  wire                   wr_en    = tick & (wr_start | ws_v_reg);
  wire [DATA_W-1:0]      rd_word  = mem[rd_idx];

  // Read data pins and status flags from registers
  assign link.q    = q_reg;
  assign link.q_oe = q_oe_reg;
  assign dll_ready = ready_reg;
  assign rd_busy   = (|rp_v_reg) | rs_v_reg;
  assign wr_busy   = (|wp_v_reg) | ws_v_reg;

  // Pin history and loop lock counting
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      k_prev_reg   <= K_RST;
      kn_prev_reg  <= K_N_RST;
      byp_prev_reg <= BYPASS_N_RST;
      stall_reg    <= '0;
      lock_cnt_reg <= '0;
      ready_reg    <= 1'b0;
    end else begin
      k_prev_reg   <= link.k;
      kn_prev_reg  <= link.k_n;
      byp_prev_reg <= link.bypass_n;
      if (!clk_static) begin
        stall_reg <= '0;
      end else if (stall_reg != '1) begin
        stall_reg <= stall_reg + STALL_W'(1);
      end
      if (loop_rst) begin
        lock_cnt_reg <= '0;
        ready_reg    <= 1'b0;
      end else if (k_rise && !ready_reg) begin
        lock_cnt_reg <= lock_cnt_reg + CNT_W'(1);
        ready_reg    <= (lock_cnt_reg == CNT_W'(LOCK_CYC - 1));
      end
    end
  end

  // Command history per true clock rise
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_last_reg   <= 1'b0;
      wr_last_reg   <= 1'b0;
      prev_idle_reg <= 1'b1;
    end else if (k_rise) begin
      rd_last_reg   <= rd_take;
      wr_last_reg   <= wr_take;
      prev_idle_reg <= ~rd_req & ~wr_req;
    end
  end

  // Read engine, independent of the write engine; frozen while clocks stand
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rp_v_reg    <= '0;
      for (int i = 0; i < RD_LAT_HALF; i++) rp_a_reg[i] <= '0;
      rs_v_reg    <= 1'b0;
      rs_a_reg    <= '0;
      rs_beat_reg <= 2'h0;
      q_reg       <= '0;
      q_oe_reg    <= 1'b0;
    end else if (tick) begin
      rp_v_reg    <= {rp_v_reg[RD_LAT_HALF-2:0], rd_take};
      rp_a_reg[0] <= link.addr;
      for (int i = 1; i < RD_LAT_HALF; i++) rp_a_reg[i] <= rp_a_reg[i-1];
      if (rd_start) begin
        q_reg       <= rd_word;
        q_oe_reg    <= 1'b1;
        rs_v_reg    <= 1'b1;
        rs_a_reg    <= rp_a_reg[RD_LAT_HALF-1];
        rs_beat_reg <= 2'h1;
      end else if (rs_v_reg) begin
        q_reg       <= rd_word;
        rs_beat_reg <= rs_beat_reg + 2'h1;
        rs_v_reg    <= (rs_beat_reg != 2'h3);
      end else begin
        q_oe_reg    <= 1'b0;
      end
    end
  end

  // Write engine: address pipeline and beat sequencing
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wp_v_reg    <= '0;
      for (int i = 0; i < WR_LAT_HALF; i++) wp_a_reg[i] <= '0;
      ws_v_reg    <= 1'b0;
      ws_a_reg    <= '0;
      ws_beat_reg <= 2'h0;
    end else if (tick) begin
      wp_v_reg    <= {wp_v_reg[WR_LAT_HALF-2:0], wr_take};
      wp_a_reg[0] <= link.addr;
      for (int i = 1; i < WR_LAT_HALF; i++) wp_a_reg[i] <= wp_a_reg[i-1];
      if (wr_start) begin
        ws_v_reg    <= 1'b1;
        ws_a_reg    <= wp_a_reg[WR_LAT_HALF-1];
        ws_beat_reg <= 2'h1;
      end else if (ws_v_reg) begin
        ws_beat_reg <= ws_beat_reg + 2'h1;
        ws_v_reg    <= (ws_beat_reg != 2'h3);
      end
    end
  end

  // Array write port
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_idx] <= link.d;
    end
  end

endmodule

// ==== verilog/sram_burst_host.sv ====
// Memory controller end: clock generation, loop reset sequencing, burst commands
`timescale 1ns/1ps
module sram_burst_host #(
  parameter int ADDR_W   = sram_link_pkg::ADDR_W_DEF,
  parameter int DATA_W   = sram_link_pkg::DATA_W_DEF,
  parameter int LOCK_CYC = sram_link_pkg::LOCK_CYCLES
) (
  input  wire logic                                     core_clk,
  input  wire logic                                     rst,
  sram_link_if.ctl                                      link,
  input  wire logic                                     relock_req,
  output logic                                          link_ready,
  input  wire logic                                     rd_req,
  input  wire logic [ADDR_W-1:0]                        rd_addr,
  output logic                                          rd_ready,
  output logic [sram_link_pkg::BURST_LEN*DATA_W-1:0]    rd_data,
  output logic                                          rd_valid,
  input  wire logic                                     wr_req,
  input  wire logic [ADDR_W-1:0]                        wr_addr,
  input  wire logic [sram_link_pkg::BURST_LEN*DATA_W-1:0] wr_data,
  output logic                                          wr_ready,
  output logic                                          busy
);
  import sram_link_pkg::*;

  localparam int BW = BURST_LEN * DATA_W;

  host_state_e             state_reg;
  host_state_e             state_next;
  logic [CNT_W-1:0]        cnt_reg;
  logic                    k_reg;
  logic                    kn_reg;
  logic                    bypass_n_reg;
  logic                    rd_sel_n_reg;
  logic                    wr_sel_n_reg;
  logic [ADDR_W-1:0]       addr_reg;
  logic [DATA_W-1:0]       d_reg;
  logic                    rd_last_reg;
  logic                    wr_last_reg;
  logic [WR_LAT_HALF-1:0]  wq_v_reg;
  logic [BW-1:0]           wq_d_reg [WR_LAT_HALF];
  logic                    ws_v_reg;
  logic [BW-1:0]           ws_d_reg;
  logic [1:0]              ws_beat_reg;
  logic [RD_CAPT_DLY-1:0]  rq_v_reg;
  logic                    rx_v_reg;
  logic [1:0]              rx_beat_reg;
  logic [BW-1:0]           rx_reg;
  logic [BW-1:0]           rd_data_reg;
  logic                    rd_valid_reg;

  // One data beat out of a whole burst word
  function automatic logic [DATA_W-1:0] beat_of(input logic [BW-1:0] w,
                                                input logic [1:0] b);
    return w[32'(b) * DATA_W +: DATA_W];
  endfunction

  // Sequencing state decode
  wire clk_run  = (state_reg == ST_LOCK) | (state_reg == ST_RUN) | (state_reg == ST_DRAIN);
  wire k_rising = clk_run & ~k_reg;
  wire run_st   = (state_reg == ST_RUN);
  wire pending  = (|wq_v_reg) | ws_v_reg | (|rq_v_reg) | rx_v_reg;
  wire pwr_done = (cnt_reg == CNT_W'(PWR_HOLD_CYC + BYPASS_LOW_CYC - 1));
  wire stop_done = (cnt_reg == CNT_W'(STOP_HOLD_CYC - 1));
  wire lock_done = k_rising & (cnt_reg == CNT_W'(LOCK_CYC + LOCK_MARGIN - 1));

  // Command acceptance: every other true rise per type, read wins a tie
  wire rd_fire = rd_req & rd_ready;
  wire wr_fire = wr_req & wr_ready;
  assign rd_ready = run_st & k_rising & ~rd_last_reg;
  assign wr_ready = run_st & k_rising & ~wr_last_reg & ~rd_fire;

  // Write serializer source selection
  wire           wr_start = wq_v_reg[WR_LAT_HALF-1];
  wire [BW-1:0]  wr_src   = wr_start ? wq_d_reg[WR_LAT_HALF-1] : ws_d_reg;
  wire [1:0]     wr_beat  = wr_start ? 2'h0 : ws_beat_reg;

  // Read capture begins when the issue marker leaves the delay line
  wire           rd_start = rq_v_reg[RD_CAPT_DLY-1];

  // Link pins and user outputs straight from their registers; link_ready and busy decoded from state_reg and the pending flags
  assign link.k        = k_reg;
  assign link.k_n      = kn_reg;
  assign link.bypass_n = bypass_n_reg;
  assign link.rd_sel_n = rd_sel_n_reg;
  assign link.wr_sel_n = wr_sel_n_reg;
  assign link.addr     = addr_reg;
  assign link.d        = d_reg;
  assign link_ready    = run_st;
  assign rd_data       = rd_data_reg;
  assign rd_valid      = rd_valid_reg;
  assign busy          = pending;

  // Next sequencing state
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_PWR:   if (pwr_done) state_next = ST_STOP;
      ST_STOP:  if (stop_done) state_next = ST_LOCK;
      ST_LOCK:  if (lock_done) state_next = ST_RUN;
      ST_RUN:   if (relock_req) state_next = ST_DRAIN;
      ST_DRAIN: if (!pending) state_next = ST_STOP;
      default:  state_next = ST_PWR;
    endcase
  end

  // State, phase counter and loop bypass pin
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg    <= ST_PWR;
      cnt_reg      <= '0;
      bypass_n_reg <= BYPASS_N_RST;
    end else begin
      state_reg <= state_next;
      if (state_next != state_reg) begin
        cnt_reg <= '0;
      end else if (state_reg != ST_LOCK || k_rising) begin
        cnt_reg <= cnt_reg + CNT_W'(1);
      end
      if (state_reg == ST_PWR && pwr_done) begin
        bypass_n_reg <= 1'b1;
      end
    end
  end

  // Clock pins toggle each core cycle while running, stand still otherwise
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      k_reg  <= K_RST;
      kn_reg <= K_N_RST;
    end else if (clk_run) begin
      k_reg  <= ~k_reg;
      kn_reg <= k_reg;
    end
  end

  // Select and address pins, driven on true clock rises
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_sel_n_reg <= SEL_N_RST;
      wr_sel_n_reg <= SEL_N_RST;
      addr_reg     <= '0;
      rd_last_reg  <= 1'b0;
      wr_last_reg  <= 1'b0;
    end else if (k_rising) begin
      rd_sel_n_reg <= ~rd_fire;
      wr_sel_n_reg <= ~wr_fire;
      addr_reg     <= rd_fire ? rd_addr : wr_addr;
      rd_last_reg  <= rd_fire;
      wr_last_reg  <= wr_fire;
    end else begin
      rd_sel_n_reg <= 1'b1;
      wr_sel_n_reg <= 1'b1;
    end
  end

  // Write data: delay to the fourth half period, then one beat per half
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wq_v_reg    <= '0;
      for (int i = 0; i < WR_LAT_HALF; i++) wq_d_reg[i] <= '0;
      ws_v_reg    <= 1'b0;
      ws_d_reg    <= '0;
      ws_beat_reg <= 2'h0;
      d_reg       <= '0;
    end else if (clk_run) begin
      wq_v_reg    <= {wq_v_reg[WR_LAT_HALF-2:0], wr_fire};
      wq_d_reg[0] <= wr_data;
      for (int i = 1; i < WR_LAT_HALF; i++) wq_d_reg[i] <= wq_d_reg[i-1];
      if (wr_start || ws_v_reg) begin
        d_reg       <= beat_of(wr_src, wr_beat);
        ws_d_reg    <= wr_src;
        ws_beat_reg <= wr_beat + 2'h1;
        ws_v_reg    <= (wr_beat != 2'h3);
      end
    end
  end

  // Read capture: first beat seen seven cycles after issue, four beats
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rq_v_reg     <= '0;
      rx_v_reg     <= 1'b0;
      rx_beat_reg  <= 2'h0;
      rx_reg       <= '0;
      rd_data_reg  <= '0;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_valid_reg <= 1'b0;
      if (clk_run) begin
        rq_v_reg <= {rq_v_reg[RD_CAPT_DLY-2:0], rd_fire};
      end
      if (rd_start) begin
        rx_reg[DATA_W-1:0] <= link.q;
        rx_beat_reg        <= 2'h1;
        rx_v_reg           <= 1'b1;
      end else if (rx_v_reg) begin
        rx_reg[32'(rx_beat_reg) * DATA_W +: DATA_W] <= link.q;
        rx_beat_reg <= rx_beat_reg + 2'h1;
        if (rx_beat_reg == 2'h3) begin
          rx_v_reg     <= 1'b0;
          rd_data_reg  <= {link.q, rx_reg[3*DATA_W-1:0]};
          rd_valid_reg <= 1'b1;
        end
      end
    end
  end

endmodule

// ==== dv/sram_link_monitor.sv ====
// Concurrent checks on the SRAM link pins
`timescale 1ns/1ps
module sram_link_monitor #(
  parameter int ADDR_W   = 19,
  parameter int DATA_W   = 36,
  parameter int LOCK_CYC = 2048
) (
  input wire logic              core_clk,
  input wire logic              rst,
  input wire logic              k,
  input wire logic              k_n,
  input wire logic              bypass_n,
  input wire logic              rd_sel_n,
  input wire logic              wr_sel_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] d,
  input wire logic [DATA_W-1:0] q,
  input wire logic              q_oe
);
  import sram_link_pkg::*;
  logic       k_d;
  logic       byp_d;
  logic [3:0] stall_cnt;
  logic [3:0] rd_age;
  int         lock_cnt;
  wire        k_rise   = k & ~k_d;
  wire        cmd_rd   = k_rise & ~rd_sel_n;
  wire        cmd_wr   = k_rise & ~wr_sel_n;
  wire        byp_rise = bypass_n & ~byp_d;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // Clock history, stall length, K rises since loop reset, age of last read
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      k_d       <= 1'b0;
      byp_d     <= 1'b0;
      stall_cnt <= 4'h0;
      rd_age    <= 4'hF;
      lock_cnt  <= 0;
    end else begin
      k_d       <= k;
      byp_d     <= bypass_n;
      stall_cnt <= (k != k_d) ? 4'h0 : (stall_cnt == 4'hF) ? stall_cnt : stall_cnt + 4'h1;
      rd_age    <= cmd_rd ? 4'h0 : (rd_age == 4'hF) ? rd_age : rd_age + 4'h1;
      lock_cnt  <= (k == k_d || byp_rise) ? 0 : lock_cnt + int'(k_rise);
    end
  end

  property p_rd_beats;
    cmd_rd |-> ##6 q_oe [*4];
  endproperty
  a_rd_beats: assert property (p_rd_beats) else $error("read beats missing on q");
  property p_idle_hiz;
    q_oe |-> rd_age <= 4'h9;
  endproperty
  a_idle_hiz: assert property (p_idle_hiz) else $error("q driven without read");
  property p_rd_space;
    cmd_rd |-> ##2 rd_sel_n;
  endproperty
  a_rd_space: assert property (p_rd_space) else $error("reads on adjacent K rises");
  property p_wr_space;
    cmd_wr |-> ##2 wr_sel_n;
  endproperty
  a_wr_space: assert property (p_wr_space) else $error("writes on adjacent K rises");
  property p_one_cmd;
    k_rise |-> (rd_sel_n || wr_sel_n);
  endproperty
  a_one_cmd: assert property (p_one_cmd) else $error("read and write on one K rise");
  property p_kn_comp;
    (k != k_d) |-> (k_n == ~k);
  endproperty
  a_kn_comp: assert property (p_kn_comp) else $error("clock pair not complementary");
  property p_stop_len;
    (k != k_d && stall_cnt != 4'h0) |-> stall_cnt >= STOP_CYC;
  endproperty
  a_stop_len: assert property (p_stop_len) else $error("clock stop too short");
  property p_lock_wait;
    (k_rise && !(rd_sel_n && wr_sel_n)) |-> lock_cnt >= LOCK_CYC;
  endproperty
  a_lock_wait: assert property (p_lock_wait) else $error("command inside lock period");
  property p_stop_hold;
    (k == k_d && k_d == $past(k_d)) |-> ($stable(q) && $stable(q_oe)
                                         && $stable(d) && $stable(addr));
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("q moved while clock stood");

  c_read: cover property (cmd_rd);
  c_ref: cover property (cmd_rd ##2 cmd_wr);
  c_bypass: cover property (byp_rise);
endmodule

// ==== dv/tb_quad_port_burst4_sram_control.sv ====
// Self-checking bench joining the SRAM device and its controller
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb_quad_port_burst4_sram_control;
  import sram_link_pkg::*;
  localparam int AW = 6;
  localparam int DW = 8;
  localparam int LK = 16;
  localparam int BW = BURST_LEN * DW;
  logic          core_clk;
  logic          rst;
  logic          relock_req;
  logic          link_ready;
  logic          rd_req;
  logic [AW-1:0] rd_addr;
  logic          rd_ready;
  logic [BW-1:0] rd_data;
  logic          rd_valid;
  logic          wr_req;
  logic [AW-1:0] wr_addr;
  logic [BW-1:0] wr_data;
  logic          wr_ready;
  logic          busy;
  logic          dll_ready;
  logic          rd_busy;
  logic          wr_busy;
  int            error_cnt;
  int            total_checks;
  int            n;

  sram_link_if #(.ADDR_W(AW), .DATA_W(DW)) link ();

  sram_burst_device #(.ADDR_W(AW), .DATA_W(DW), .LOCK_CYC(LK)) sram_burst_device_i (
    .core_clk  (core_clk),
    .rst       (rst),
    .link      (link.dev),
    .dll_ready (dll_ready),
    .rd_busy   (rd_busy),
    .wr_busy   (wr_busy)
  );

  sram_burst_host #(.ADDR_W(AW), .DATA_W(DW), .LOCK_CYC(LK)) sram_burst_host_i (
    .core_clk   (core_clk),
    .rst        (rst),
    .link       (link.ctl),
    .relock_req (relock_req),
    .link_ready (link_ready),
    .rd_req     (rd_req),
    .rd_addr    (rd_addr),
    .rd_ready   (rd_ready),
    .rd_data    (rd_data),
    .rd_valid   (rd_valid),
    .wr_req     (wr_req),
    .wr_addr    (wr_addr),
    .wr_data    (wr_data),
    .wr_ready   (wr_ready),
    .busy       (busy)
  );

  sram_link_monitor #(.ADDR_W(AW), .DATA_W(DW), .LOCK_CYC(LK)) sram_link_monitor_i (
    .core_clk (core_clk),
    .rst      (rst),
    .k        (link.k),
    .k_n      (link.k_n),
    .bypass_n (link.bypass_n),
    .rd_sel_n (link.rd_sel_n),
    .wr_sel_n (link.wr_sel_n),
    .addr     (link.addr),
    .d        (link.d),
    .q        (link.q),
    .q_oe     (link.q_oe)
  );

  // Core clock, 20 ns period
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Verdict and end of run
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Write one burst and watch its beats on the data-in pins
  task automatic wr_burst(input logic [AW-1:0] a, input logic [BW-1:0] v);
    int c;
    c = 0;
    wr_req  <= 1'b1;
    wr_addr <= a;
    wr_data <= v;
    do begin
      @(posedge core_clk);
      c++;
    end while (wr_ready !== 1'b1 && c < 50);
    wr_req <= 1'b0;
    `CHK("wr taken", 1'b1, wr_ready)
    repeat (3) @(posedge core_clk);
    #1 `CHK("wr busy", 2'h3, {busy, wr_busy})
    for (int i = 0; i < BURST_LEN; i++) begin
      @(posedge core_clk);
      #1 `CHK("d beat", v[i*DW +: DW], link.d)
    end
    @(posedge core_clk);
  endtask

  // Read one burst, check beats on the pins and the assembled result
  task automatic rd_burst(input logic [AW-1:0] a, input logic [BW-1:0] v);
    int c;
    c = 0;
    rd_req  <= 1'b1;
    rd_addr <= a;
    do begin
      @(posedge core_clk);
      c++;
    end while (rd_ready !== 1'b1 && c < 50);
    rd_req <= 1'b0;
    `CHK("rd taken", 1'b1, rd_ready)
    repeat (5) @(posedge core_clk);
    #1 `CHK("rd busy", 2'h3, {busy, rd_busy})
    for (int i = 0; i < BURST_LEN; i++) begin
      @(posedge core_clk);
      #1 `CHK("q beat", {1'b1, v[i*DW +: DW]}, {link.q_oe, link.q})
    end
    `CHK("rd valid early", 1'b0, rd_valid)
    @(posedge core_clk);
    #1 `CHK("rd valid", 1'b1, rd_valid)
    `CHK("rd data", v, rd_data)
    @(posedge core_clk);
  endtask

  // Hang guard
  initial begin
    repeat (3000) @(posedge core_clk);
    error_cnt++;
    wrap_up();
  end

  // Main sequence
  initial begin
    rst          = 1'b1;
    relock_req   = 1'b0;
    rd_req       = 1'b0;
    rd_addr      = '0;
    wr_req       = 1'b0;
    wr_addr      = '0;
    wr_data      = '0;
    error_cnt    = 0;
    total_checks = 0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    // Power-up: bypass release, clock stop, lock period
    repeat (20) @(posedge core_clk);
    `CHK("dll early", 1'b0, dll_ready)
    n = 0;
    while (link_ready !== 1'b1 && n < 400) begin @(posedge core_clk); n++; end
    `CHK("dll locked", 1'b1, dll_ready)
    // Plain write and read back
    wr_burst(6'h05, 32'hA1B2C3D4);
    rd_burst(6'h05, 32'hA1B2C3D4);
    // Read and write requested together: read first, write next K rise
    fork
      rd_burst(6'h05, 32'hA1B2C3D4);
      wr_burst(6'h3F, 32'h5E6F7081);
    join
    rd_burst(6'h3F, 32'h5E6F7081);
    // Held read request: the next K rise is refused, the one after taken
    rd_addr <= 6'h05;
    rd_req  <= 1'b1;
    n = 0;
    do begin @(posedge core_clk); n++; end while (rd_ready !== 1'b1 && n < 50);
    repeat (2) @(posedge core_clk);
    `CHK("rd refused", 1'b0, rd_ready)
    repeat (2) @(posedge core_clk);
    `CHK("rd again", 1'b1, rd_ready)
    rd_req <= 1'b0;
    repeat (20) @(posedge core_clk);
    `CHK("idle", 3'h0, {busy, rd_busy, wr_busy})
    // Relock: drain, clock stop, lock period, array kept
    relock_req <= 1'b1;
    n = 0;
    while (dll_ready !== 1'b0 && n < 100) begin @(posedge core_clk); n++; end
    relock_req <= 1'b0;
    `CHK("dll reset", 1'b0, dll_ready)
    `CHK("link down", 1'b0, link_ready)
    n = 0;
    while (link_ready !== 1'b1 && n < 400) begin @(posedge core_clk); n++; end
    `CHK("relocked", 1'b1, dll_ready)
    rd_burst(6'h3F, 32'h5E6F7081);
    wrap_up();
  end
endmodule
